// File: dv/dcr_control_properties.sv
`timescale 1ns/100ps
module dcr_control_properties (
  input logic core_clk,
  input logic rst_n,
  input logic cmd_valid,
  input dcr_pkg::dcr_cmd_t cmd,
  input logic load_dac_n,
  input logic die_over_temp,
  input dcr_pkg::dcr_cfg_t cfg,
  input logic amps_enabled,
  input logic refs_enabled,
  input logic thermal_shutdown,
  input logic [5:0] monitor_select,
  input logic monitor_output_pin_oe,
  input logic [15:0] channel_b_select
);
  import dcr_pkg::*;
  logic wr_c, wr_m, wr_p, mon_on;
  assign wr_c = cmd_valid && cmd[19:14] == 6'h0C;
  assign wr_m = cmd_valid && cmd[19:14] == 6'h0A;
  assign wr_p = cmd_valid && cmd[19:14] == 6'h09;
  assign mon_on = cfg.chan_monitor_enable_bit && monitor_select != 6'h3F;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_cfg_load: assert property (wr_c |=> cfg[7:2] == $past(cmd.data[13:8])) else $error("cfg load");
  chk_tog_load: assert property (wr_c |=> cfg[1:0] == $past(cmd.data[3:2])) else $error("toggle load");
  chk_cfg_hold: assert property (!wr_c |=> $stable(cfg)) else $error("cfg moved");
  chk_therm_trip: assert property (cfg.thermal_guard_enable_bit && die_over_temp
    |=> thermal_shutdown && !amps_enabled) else $error("no trip");
  chk_guard_off: assert property (!cfg.thermal_guard_enable_bit && !thermal_shutdown |=> !thermal_shutdown)
    else $error("trip while guard off");
  chk_stay_off: assert property (thermal_shutdown && die_over_temp |=> thermal_shutdown) else $error("early wake");
  chk_wake_up: assert property (thermal_shutdown && !die_over_temp && wr_p
    |=> !thermal_shutdown && amps_enabled) else $error("no wake");
  chk_refs_up: assert property (wr_p |=> refs_enabled) else $error("refs off");
  chk_mon_sel: assert property (wr_m |=> monitor_select == $past(cmd.data[13:8])) else $error("mon sel");
  chk_mon_oe: assert property (1'b1 |-> monitor_output_pin_oe == mon_on) else $error("mon oe");
  chk_toggle_swap: assert property ($fell(load_dac_n) && cfg.toggle_group_lo_enable && !wr_c
    |=> channel_b_select[7:0] == ~$past(channel_b_select[7:0])) else $error("no swap");
  cov_trip: cover property (thermal_shutdown);
  cov_swap: cover property ($fell(load_dac_n) && cfg.toggle_group_lo_enable);
  cov_mon: cover property (monitor_output_pin_oe);
endmodule
bind dcr_control dcr_control_properties i_dcr_control_properties (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .cmd_valid(cmd_valid),
  .cmd(cmd),
  .load_dac_n(load_dac_n),
  .die_over_temp(die_over_temp),
  .cfg(cfg),
  .amps_enabled(amps_enabled),
  .refs_enabled(refs_enabled),
  .thermal_shutdown(thermal_shutdown),
  .monitor_select(monitor_select),
  .monitor_output_pin_oe(monitor_output_pin_oe),
  .channel_b_select(channel_b_select)
);

// File: dv/dcr_host_model.sv
`timescale 1ns/100ps
module dcr_host_model (
  output logic cmd_valid,
  output dcr_pkg::dcr_cmd_t cmd,
  input logic core_clk
);
  import dcr_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Idle bus shows inverted junk, never a stale word
  task automatic send(input logic [1:0] s, input logic [3:0] a, input logic [13:0] d);
    @(negedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= {s, a, d};
    @(negedge core_clk);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
  endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import dcr_pkg::*;
  logic core_clk, rst_n, cmd_valid, load_dac_n, die_over_temp;
  logic amps_enabled, refs_enabled, thermal_shutdown, monitor_output_pin_oe;
  logic [5:0] monitor_select;
  logic [15:0] channel_b_select;
  dcr_cmd_t cmd;
  dcr_cfg_t cfg;
  int fails, check_count;
  dcr_control i_dcr_control (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .load_dac_n(load_dac_n),
    .die_over_temp(die_over_temp),
    .cfg(cfg),
    .amps_enabled(amps_enabled),
    .refs_enabled(refs_enabled),
    .thermal_shutdown(thermal_shutdown),
    .monitor_select(monitor_select),
    .monitor_output_pin_oe(monitor_output_pin_oe),
    .channel_b_select(channel_b_select)
  );
  dcr_host_model i_dcr_host_model (
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .core_clk(core_clk)
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Falling edge of the strobe is one toggle
  task automatic pulse();
    @(negedge core_clk);
    load_dac_n = 1'b0;
    @(negedge core_clk);
    load_dac_n = 1'b1;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    load_dac_n = 1'b1;
    die_over_temp = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    chk({cfg, amps_enabled, refs_enabled, thermal_shutdown}, {8'hC0, 3'h6});
    chk({monitor_output_pin_oe, monitor_select}, 7'h3F);
    i_dcr_host_model.send(2'h0, 4'hC, 14'h3FFF);
    chk(cfg, 8'hFF);
    i_dcr_host_model.send(2'h0, 4'hC, 14'h00F3);
    chk(cfg, 8'h00);
    i_dcr_host_model.send(2'h1, 4'hC, 14'h3FFF);
    i_dcr_host_model.send(2'h0, 4'hB, 14'h3FFF);
    chk(cfg, 8'h00);
    i_dcr_host_model.send(2'h0, 4'hC, 14'h030C);
    chk(cfg, 8'h0F);
    pulse();
    chk(channel_b_select, 16'hFFFF);
    pulse();
    chk(channel_b_select, 16'h0000);
    i_dcr_host_model.send(2'h0, 4'hA, 14'h0500);
    chk(monitor_select, 6'h05);
    @(negedge core_clk);
    chk(monitor_output_pin_oe, 1'h1);
    die_over_temp = 1'b1;
    @(negedge core_clk);
    chk({amps_enabled, thermal_shutdown}, 2'h1);
    i_dcr_host_model.send(2'h0, 4'h9, 14'h0000);
    chk(thermal_shutdown, 1'h1);
    die_over_temp = 1'b0;
    i_dcr_host_model.send(2'h0, 4'h9, 14'h0000);
    chk({amps_enabled, thermal_shutdown, refs_enabled}, 3'h5);
    i_dcr_host_model.send(2'h0, 4'hA, 14'h3F00);
    chk({monitor_output_pin_oe, monitor_select}, 7'h3F);
    i_dcr_host_model.send(2'h0, 4'hC, 14'h0008);
    chk(cfg, 8'h02);
    die_over_temp = 1'b1;
    pulse();
    chk({thermal_shutdown, channel_b_select}, 17'h0FF00);
    die_over_temp = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    chk({cfg, channel_b_select}, 24'hC00000);
    i_dcr_host_model.send(2'h0, 4'hC, 14'h0204);
    chk(cfg, 8'h09);
    end_sim();
  end
endmodule

// File: hw/dcr_control.sv
// Behaviour
// - Command with select bits 00 and address 1100 loads the control register.
// - Top bit: set gives high-impedance outputs in power-down, clear gives 100k to ground.
// - Reference level bit: 1 is 2.5 V, 0 is 1.25 V; default per variant.
// - Boost bit set raises amplifier bias current; cleared by default.
// - Reference source bit: set uses internal reference, clear (default) external.
// - Monitor enable bit lets monitor-channel commands drive the monitor output.
// - Thermal guard enable bit, cleared at power-up.
// - Guard enabled and die over 130 C powers down all output amplifiers.
// - Soft power-up restores amplifiers after shutdown only when die below 130 C.
// - Toggle enables for channels 8-15 and 0-7; 1 enables, 0 disables.
// - Eight-channel variant honours only the lower toggle enable.
// - In enabled groups each load pulse swaps a channel between A and B codes.
// - Twelve-bit variant uses same command but a 12-bit register layout.
// - Monitor command carries the channel address in its upper data bits.
// - Soft power-up command, address 1001, powers up amplifiers and references.
`timescale 1ns/100ps
`include "dcr_regs.svh"
module dcr_control #(
  parameter bit WIDE_VARIANT = 1'b1,
  parameter bit SIXTEEN_CHANNELS = 1'b1,
  parameter bit REF_2V5_DEFAULT = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire dcr_pkg::dcr_cmd_t cmd,
  input wire logic load_dac_n,
  input wire logic die_over_temp,
  output dcr_pkg::dcr_cfg_t cfg,
  output logic amps_enabled,
  output logic refs_enabled,
  output logic thermal_shutdown,
  output logic [5:0] monitor_select,
  output logic monitor_output_pin_oe,
  output logic [15:0] channel_b_select
);
  import dcr_pkg::*;

  dcr_cfg_t cfg_r, cfg_nxt;
  dcr_amp_state_t amp_r, amp_nxt;
  // Decodes of the shutdown state, held in their own flops
  logic amps_en_r, amps_en_nxt;
  logic shut_r, shut_nxt;
  logic refs_r, refs_nxt;
  logic [5:0] mon_sel_r, mon_sel_nxt;
  logic mon_oe_r, mon_oe_nxt;
  logic load_prev_r, load_prev_nxt;
  logic [15:0] bsel_r, bsel_nxt;
  logic is_sel, wr_ctrl, wr_mon, wr_pwrup, load_pulse;
  logic [13:0] d;

  assign is_sel = cmd_valid && !cmd.reg_select_hi && !cmd.reg_select_lo;
  assign wr_ctrl = is_sel && (cmd.command_address_bits == `DCR_ADDR_CONTROL);
  assign wr_mon = is_sel && (cmd.command_address_bits == `DCR_ADDR_MONITOR);
  assign wr_pwrup = is_sel && (cmd.command_address_bits == `DCR_ADDR_SOFT_PWRUP);
  assign d = cmd.data;
  // Falling edge of the load strobe; pins arrive synchronous
  assign load_pulse = load_prev_r && !load_dac_n;

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_ctrl) begin
      // Only named positions are picked; the rest are dropped
      if (WIDE_VARIANT) begin
        cfg_nxt.amp_powerdown_state_bit = d[`DCR_W14_PD_STATE];
        cfg_nxt.ref_level_select_bit = d[`DCR_W14_REF_LEVEL];
        cfg_nxt.amp_boost_bit = d[`DCR_W14_BOOST];
        cfg_nxt.int_ref_enable_bit = d[`DCR_W14_INT_REF];
        cfg_nxt.chan_monitor_enable_bit = d[`DCR_W14_MON_EN];
        cfg_nxt.thermal_guard_enable_bit = d[`DCR_W14_THERM_EN];
        cfg_nxt.toggle_group_hi_enable = d[`DCR_W14_TOG_HI] && SIXTEEN_CHANNELS;
        cfg_nxt.toggle_group_lo_enable = d[`DCR_W14_TOG_LO];
      end else begin
        cfg_nxt.amp_powerdown_state_bit = d[`DCR_W12_PD_STATE];
        cfg_nxt.ref_level_select_bit = d[`DCR_W12_REF_LEVEL];
        cfg_nxt.amp_boost_bit = d[`DCR_W12_BOOST];
        cfg_nxt.int_ref_enable_bit = d[`DCR_W12_INT_REF];
        cfg_nxt.chan_monitor_enable_bit = d[`DCR_W12_MON_EN];
        cfg_nxt.thermal_guard_enable_bit = d[`DCR_W12_THERM_EN];
        cfg_nxt.toggle_group_hi_enable = d[`DCR_W12_TOG_HI] && SIXTEEN_CHANNELS;
        cfg_nxt.toggle_group_lo_enable = d[`DCR_W12_TOG_LO];
      end
    end
  end

  always_comb begin
    mon_sel_nxt = mon_sel_r;
    if (wr_mon) begin
      if (WIDE_VARIANT) begin
        mon_sel_nxt = d[`DCR_W14_MON_SEL_LSB +: 6];
      end else begin
        mon_sel_nxt = d[`DCR_W12_MON_SEL_LSB +: 6];
      end
    end
    // Monitor stays off while disabled or parked on the off address
    mon_oe_nxt = cfg_nxt.chan_monitor_enable_bit && (mon_sel_nxt != `DCR_MON_SEL_OFF);
  end

  always_comb begin
    amp_nxt = amp_r;
    case (amp_r)
      DCR_AMP_ON: begin
        // Guard acts within one cycle; the comparator sits in the analog side
        if (cfg_r.thermal_guard_enable_bit && die_over_temp) begin
          amp_nxt = DCR_AMP_THERMAL_OFF;
        end
      end
      DCR_AMP_THERMAL_OFF: begin
        if (wr_pwrup && !die_over_temp) begin
          amp_nxt = DCR_AMP_ON;
        end
      end
      default: begin
        amp_nxt = DCR_AMP_ON;
      end
    endcase
    // Decodes computed ahead so the pins come straight from flops
    amps_en_nxt = (amp_nxt == DCR_AMP_ON);
    shut_nxt = (amp_nxt == DCR_AMP_THERMAL_OFF);
  end

  // Nothing in this block powers the references down
  always_comb begin
    refs_nxt = refs_r;
    if (wr_pwrup) begin
      refs_nxt = 1'h1;
    end
  end

  always_comb begin
    load_prev_nxt = load_dac_n;
  end

  genvar ch;
  generate
    for (ch = 0; ch < `DCR_CHANNELS; ch++) begin : g_tog
      logic grp_en;
      if (ch < `DCR_GROUP_SIZE) begin : g_lo
        assign grp_en = cfg_r.toggle_group_lo_enable;
      end else begin : g_hi
        assign grp_en = cfg_r.toggle_group_hi_enable;
      end
      always_comb begin
        bsel_nxt[ch] = bsel_r[ch];
        if (!grp_en) begin
          bsel_nxt[ch] = 1'h0;
        end else if (load_pulse) begin
          bsel_nxt[ch] = !bsel_r[ch];
        end
      end
    end
  endgenerate

  // Reference level default differs per variant, hence the parameter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_r.amp_powerdown_state_bit <= `DCR_RST_PD_STATE;
      cfg_r.ref_level_select_bit <= REF_2V5_DEFAULT;
      cfg_r.amp_boost_bit <= `DCR_RST_BOOST;
      cfg_r.int_ref_enable_bit <= `DCR_RST_INT_REF;
      cfg_r.chan_monitor_enable_bit <= `DCR_RST_MON_EN;
      cfg_r.thermal_guard_enable_bit <= `DCR_RST_THERM_EN;
      cfg_r.toggle_group_hi_enable <= `DCR_RST_TOG;
      cfg_r.toggle_group_lo_enable <= `DCR_RST_TOG;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Amplifiers come up powered; a trip holds until a safe soft power-up
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      amp_r <= DCR_AMP_ON;
      amps_en_r <= `DCR_RST_AMPS_EN;
      shut_r <= `DCR_RST_SHUTDOWN;
    end else begin
      amp_r <= amp_nxt;
      amps_en_r <= amps_en_nxt;
      shut_r <= shut_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      refs_r <= `DCR_RST_REFS;
    end else begin
      refs_r <= refs_nxt;
    end
  end

  // Off address at reset keeps the monitor pin released
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mon_sel_r <= `DCR_MON_SEL_OFF;
      mon_oe_r <= `DCR_RST_MON_OE;
    end else begin
      mon_sel_r <= mon_sel_nxt;
      mon_oe_r <= mon_oe_nxt;
    end
  end

  // Idle-high start so leaving reset with the strobe idle high never fakes a load pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      load_prev_r <= `DCR_RST_LOAD_IDLE;
      bsel_r <= `DCR_RST_BSEL;
    end else begin
      load_prev_r <= load_prev_nxt;
      bsel_r <= bsel_nxt;
    end
  end

  assign cfg = cfg_r;
  assign amps_enabled = amps_en_r;
  assign thermal_shutdown = shut_r;
  assign refs_enabled = refs_r;
  assign monitor_select = mon_sel_r;
  assign monitor_output_pin_oe = mon_oe_r;
  assign channel_b_select = bsel_r;
endmodule

// File: hw/dcr_pkg.sv
package dcr_pkg;
  typedef struct packed {
    logic reg_select_hi;
    logic reg_select_lo;
    logic [3:0] command_address_bits;
    logic [13:0] data;
  } dcr_cmd_t;

  typedef struct packed {
    logic amp_powerdown_state_bit;
    logic ref_level_select_bit;
    logic amp_boost_bit;
    logic int_ref_enable_bit;
    logic chan_monitor_enable_bit;
    logic thermal_guard_enable_bit;
    logic toggle_group_hi_enable;
    logic toggle_group_lo_enable;
  } dcr_cfg_t;

  typedef enum logic [1:0] {
    DCR_AMP_ON = 2'b01,
    DCR_AMP_THERMAL_OFF = 2'b10
  } dcr_amp_state_t;
endpackage

// File: hw/dcr_regs.svh
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

`define DCR_ADDR_CONTROL 4'hC
`define DCR_ADDR_MONITOR 4'hA
`define DCR_ADDR_SOFT_PWRUP 4'h9

`define DCR_W14_PD_STATE 13
`define DCR_W14_REF_LEVEL 12
`define DCR_W14_BOOST 11
`define DCR_W14_INT_REF 10
`define DCR_W14_MON_EN 9
`define DCR_W14_THERM_EN 8
`define DCR_W14_TOG_HI 3
`define DCR_W14_TOG_LO 2
`define DCR_W14_MON_SEL_LSB 8

`define DCR_W12_PD_STATE 11
`define DCR_W12_REF_LEVEL 10
`define DCR_W12_BOOST 9
`define DCR_W12_INT_REF 8
`define DCR_W12_MON_EN 7
`define DCR_W12_THERM_EN 6
`define DCR_W12_TOG_HI 1
`define DCR_W12_TOG_LO 0
`define DCR_W12_MON_SEL_LSB 6

`define DCR_RST_PD_STATE 1'h1
`define DCR_RST_BOOST 1'h0
`define DCR_RST_INT_REF 1'h0
`define DCR_RST_MON_EN 1'h0
`define DCR_RST_THERM_EN 1'h0
`define DCR_RST_TOG 1'h0
`define DCR_RST_REFS 1'h1
`define DCR_RST_AMPS_EN 1'h1
`define DCR_RST_SHUTDOWN 1'h0
`define DCR_RST_MON_OE 1'h0
`define DCR_RST_LOAD_IDLE 1'h1
`define DCR_RST_BSEL 16'h0000
`define DCR_MON_SEL_OFF 6'h3F
`define DCR_CHANNELS 16
`define DCR_GROUP_SIZE 8

`endif
